// File: shared/usage_monitor_pkg.sv
// constants and types shared by the usage monitor readout design
package usage_monitor_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 12;
    localparam int          VALUE_W         = 31;
    localparam int          INDEX_W         = 16;
    localparam int          NOT_READY_BIT   = 31;
    // byte offsets inside each feature page
    localparam logic [11:0] SELECTOR_OFS    = 12'h800;
    localparam logic [11:0] STORAGE_SNAP_OFS = 12'h848;
    localparam logic [11:0] BW_COUNTER_OFS  = 12'h860;
    localparam logic [11:0] BW_SNAP_OFS     = 12'h868;
    // reset values
    localparam logic [15:0] SELECTOR_RST    = 16'h0000;
    localparam logic [31:0] SNAPSHOT_RST    = 32'h8000_0000;
    // bank numbering: index 1 is the secure bank
    localparam int          NUM_BANKS       = 2;
    localparam int          BANK_NONSECURE  = 0;
    localparam int          BANK_SECURE     = 1;
    typedef logic [VALUE_W-1:0] value_t;
    typedef logic [INDEX_W-1:0] index_t;
    typedef logic [DATA_W-1:0]  word_t;
    typedef logic [ADDR_W-1:0]  addr_t;
endpackage

// File: shared/scale_if.sv
// carrier between the readout top and one bandwidth scaler
`timescale 1ns/1ps
interface scale_if #(
    parameter int COUNT_W = 44
);
    logic [COUNT_W-1:0] raw_count;
    logic               scaling_enable;
    logic [30:0]        live_value;
    modport owner  (output raw_count, output scaling_enable, input live_value);
    modport scaler (input raw_count, input scaling_enable, output live_value);
endinterface

// File: hdl/bandwidth_scaler.sv
// scales one raw byte count into the 31-bit live counter field
`timescale 1ns/1ps
module bandwidth_scaler #(
    parameter int COUNT_W = 44,
    parameter int SCALE   = 0
) (
    scale_if.scaler port
);
    localparam int             SHIFT_M1 = (SCALE > 0) ? SCALE - 1 : 0;
    localparam logic [COUNT_W:0] ONE    = {{COUNT_W{1'b0}}, 1'b1};
    localparam logic [COUNT_W:0] HALF   = (SCALE > 0) ? (ONE << SHIFT_M1)
                                                      : '0;

    logic [COUNT_W:0] widened;
    logic [COUNT_W:0] rounded;

    // round to nearest by adding half a step before the shift
    always_comb begin
        widened = {1'b0, port.raw_count};
        rounded = (widened + HALF) >> SCALE;
        if (port.scaling_enable) begin
            port.live_value = rounded[30:0]; // R05
        end else begin
            port.live_value = widened[30:0]; // R03
        end
    end
endmodule // bandwidth_scaler

// File: hdl/usage_monitor_readout.sv
// banked readout registers for storage and bandwidth usage monitors
// Function
// R01: storage snapshot bits 30:0 hold captured bytes of selected monitor.
// R02: storage snapshot bit 31 is not-ready flag; value invalid while it is 1.
// R03: live bandwidth field holds filtered byte count since monitor reset.
// R04: live bandwidth bit 31 is not-ready flag; value invalid while it is 1.
// R05: with scaling enabled report byte count shifted right by scale, rounded.
// R06: bandwidth snapshot bit 31 is captured copy of live not-ready flag.
// R07: bandwidth snapshot value equals live field at capture, scaling kept.
// R08: without its support flags a register reads zero and ignores writes.
// R09: separate secure and non-secure instances, each indexed by own selector.
// R10: secure page reaches secure instances only, non-secure page the rest.
// R11: all three registers are 32 bits, readable and writable by software.
// R12: selector holds 16-bit index routing accesses to the named monitor.
// R13: capture copies flag and value of every monitor together in one cycle; the code captures only banks whose CAPTURE_EVENT bit is set.
`timescale 1ns/1ps
module usage_monitor_readout
    import usage_monitor_pkg::*;
#(
    parameter int NUM_MON    = 4,
    parameter int BW_COUNT_W = 44,
    parameter int SCALE      = 0
) (
    input  wire logic                                  CORE_CLK,
    input  wire logic                                  RESET,
    input  wire logic                                  REQ_VALID,
    input  wire logic                                  REQ_WRITE,
    input  wire logic                                  REQ_SECURE,
    input  wire usage_monitor_pkg::addr_t              REQ_ADDR,
    input  wire usage_monitor_pkg::word_t              REQ_WDATA,
    output logic                                       RSP_VALID,
    output usage_monitor_pkg::word_t                   RSP_RDATA,
    input  wire logic                                  MONITORING_SUPPORTED,
    input  wire logic                                  STORAGE_MON_SUPPORTED,
    input  wire logic                                  STORAGE_CAPTURE_SUPPORTED,
    input  wire logic                                  BW_MON_SUPPORTED,
    input  wire logic                                  BW_CAPTURE_SUPPORTED,
    input  wire usage_monitor_pkg::value_t [1:0][NUM_MON-1:0] STORAGE_USAGE,
    input  wire logic [1:0][NUM_MON-1:0]               STORAGE_NOT_READY,
    input  wire logic [1:0][NUM_MON-1:0][BW_COUNT_W-1:0] BW_BYTE_COUNT,
    input  wire logic [1:0][NUM_MON-1:0]               BW_NOT_READY,
    input  wire logic [1:0][NUM_MON-1:0]               BW_SCALING_ENABLE,
    input  wire logic [1:0]                            CAPTURE_EVENT,
    output logic                                       BW_WRITE_VALID,
    output logic                                       BW_WRITE_SECURE,
    output usage_monitor_pkg::index_t                  BW_WRITE_INDEX,
    output usage_monitor_pkg::word_t                   BW_WRITE_DATA
);
    import usage_monitor_pkg::*;

    localparam int MIDX_W = (NUM_MON > 1) ? $clog2(NUM_MON) : 1;
    localparam index_t NUM_MON_IDX = index_t'(NUM_MON);

    // register state and next values
    index_t [NUM_BANKS-1:0]              selector_reg;
    index_t [NUM_BANKS-1:0]              selector_next;
    word_t  [NUM_BANKS-1:0][NUM_MON-1:0] storage_snap_reg;
    word_t  [NUM_BANKS-1:0][NUM_MON-1:0] storage_snap_next;
    word_t  [NUM_BANKS-1:0][NUM_MON-1:0] bw_snap_reg;
    word_t  [NUM_BANKS-1:0][NUM_MON-1:0] bw_snap_next;
    logic                                rsp_valid_reg;
    logic                                rsp_valid_next;
    word_t                               rdata_reg;
    word_t                               rdata_next;
    logic                                bw_wr_valid_reg;
    logic                                bw_wr_valid_next;
    logic                                bw_wr_secure_reg;
    logic                                bw_wr_secure_next;
    index_t                              bw_wr_index_reg;
    index_t                              bw_wr_index_next;
    word_t                               bw_wr_data_reg;
    word_t                               bw_wr_data_next;

    // scaled live counter field of every monitor
    value_t [NUM_BANKS-1:0][NUM_MON-1:0] bw_live;

    // access decode helpers
    logic              bank;
    index_t            sel_index;
    logic [MIDX_W-1:0] midx;
    logic              in_range;
    logic              storage_snap_ok;
    logic              bw_counter_ok;
    logic              bw_snap_ok;

    // a register exists only when all of its support flags are set
    function automatic logic reg_present(
        input logic monitoring,
        input logic type_ok,
        input logic needs_capture,
        input logic capture_ok
    );
        reg_present = monitoring & type_ok & (~needs_capture | capture_ok);
    endfunction

    // one scaler per monitor in each bank
    genvar gb;
    genvar gm;
    generate
        for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
            for (gm = 0; gm < NUM_MON; gm++) begin : g_mon
                scale_if #(.COUNT_W(BW_COUNT_W)) sif ();
                assign sif.raw_count      = BW_BYTE_COUNT[gb][gm];
                assign sif.scaling_enable = BW_SCALING_ENABLE[gb][gm];
                assign bw_live[gb][gm]    = sif.live_value;
                bandwidth_scaler #(
                    .COUNT_W (BW_COUNT_W),
                    .SCALE   (SCALE)
                ) u_scaler (
                    .port (sif.scaler)
                );
            end
        end
    endgenerate

    // page and selector decode of the current access
    always_comb begin
        bank      = REQ_SECURE; // R10
        sel_index = selector_reg[bank]; // R09
        midx      = sel_index[MIDX_W-1:0];
        in_range  = (sel_index < NUM_MON_IDX); // R12
        storage_snap_ok = reg_present(MONITORING_SUPPORTED,
                                      STORAGE_MON_SUPPORTED, 1'b1,
                                      STORAGE_CAPTURE_SUPPORTED); // R08
        bw_counter_ok   = reg_present(MONITORING_SUPPORTED,
                                      BW_MON_SUPPORTED, 1'b0,
                                      1'b0); // R08
        bw_snap_ok      = reg_present(MONITORING_SUPPORTED,
                                      BW_MON_SUPPORTED, 1'b1,
                                      BW_CAPTURE_SUPPORTED); // R08
    end

    // next state: software access first, capture afterwards so it wins
    always_comb begin
        selector_next     = selector_reg;
        storage_snap_next = storage_snap_reg;
        bw_snap_next      = bw_snap_reg;
        rsp_valid_next    = REQ_VALID;
        rdata_next        = '0;
        bw_wr_valid_next  = 1'b0;
        bw_wr_secure_next = bw_wr_secure_reg;
        bw_wr_index_next  = bw_wr_index_reg;
        bw_wr_data_next   = bw_wr_data_reg;
        if (REQ_VALID) begin
            unique case (REQ_ADDR)
                SELECTOR_OFS: begin
                    if (MONITORING_SUPPORTED) begin
                        rdata_next = {{(DATA_W-INDEX_W){1'b0}}, sel_index};
                        if (REQ_WRITE) begin
                            selector_next[bank] = REQ_WDATA[INDEX_W-1:0]; // R12
                        end
                    end
                end
                STORAGE_SNAP_OFS: begin
                    if (storage_snap_ok && in_range) begin
                        rdata_next = storage_snap_reg[bank][midx]; // R01
                        if (REQ_WRITE) begin
                            storage_snap_next[bank][midx] = REQ_WDATA; // R11
                        end
                    end
                end
                BW_COUNTER_OFS: begin
                    if (bw_counter_ok && in_range) begin
                        rdata_next = {BW_NOT_READY[bank][midx],
                                      bw_live[bank][midx]}; // R04
                        if (REQ_WRITE) begin
                            bw_wr_valid_next  = 1'b1; // R11
                            bw_wr_secure_next = bank;
                            bw_wr_index_next  = sel_index;
                            bw_wr_data_next   = REQ_WDATA;
                        end
                    end
                end
                BW_SNAP_OFS: begin
                    if (bw_snap_ok && in_range) begin
                        rdata_next = bw_snap_reg[bank][midx]; // R06
                        if (REQ_WRITE) begin
                            bw_snap_next[bank][midx] = REQ_WDATA; // R11
                        end
                    end
                end
                default: begin
                    rdata_next = '0; // unmapped offsets read zero
                end
            endcase
            if (REQ_WRITE) begin
                rdata_next = '0;
            end
        end
        // capture copies flag and value of each monitor of a bank whose CAPTURE_EVENT bit is set, in the same cycle
        for (int b = 0; b < NUM_BANKS; b++) begin
            if (CAPTURE_EVENT[b]) begin
                for (int m = 0; m < NUM_MON; m++) begin
                    storage_snap_next[b][m] = {STORAGE_NOT_READY[b][m],
                                               STORAGE_USAGE[b][m]}; // R13
                    bw_snap_next[b][m] = {BW_NOT_READY[b][m],
                                          bw_live[b][m]}; // R07
                end
            end
        end
    end

    // register stage
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            selector_reg     <= {NUM_BANKS{SELECTOR_RST}};
            storage_snap_reg <= {(NUM_BANKS*NUM_MON){SNAPSHOT_RST}};
            bw_snap_reg      <= {(NUM_BANKS*NUM_MON){SNAPSHOT_RST}};
            rsp_valid_reg    <= 1'b0;
            rdata_reg        <= '0;
            bw_wr_valid_reg  <= 1'b0;
            bw_wr_secure_reg <= 1'b0;
            bw_wr_index_reg  <= '0;
            bw_wr_data_reg   <= '0;
        end else begin
            selector_reg     <= selector_next;
            storage_snap_reg <= storage_snap_next;
            bw_snap_reg      <= bw_snap_next;
            rsp_valid_reg    <= rsp_valid_next;
            rdata_reg        <= rdata_next;
            bw_wr_valid_reg  <= bw_wr_valid_next;
            bw_wr_secure_reg <= bw_wr_secure_next;
            bw_wr_index_reg  <= bw_wr_index_next;
            bw_wr_data_reg   <= bw_wr_data_next;
        end
    end

    // outputs straight from flip-flops
    assign RSP_VALID       = rsp_valid_reg;
    assign RSP_RDATA       = rdata_reg; // R02
    assign BW_WRITE_VALID  = bw_wr_valid_reg;
    assign BW_WRITE_SECURE = bw_wr_secure_reg;
    assign BW_WRITE_INDEX  = bw_wr_index_reg;
    assign BW_WRITE_DATA   = bw_wr_data_reg;
endmodule // usage_monitor_readout

// File: testbench/usage_monitor_readout_monitor.sv
// port checker for the usage monitor readout block
`timescale 1ns/1ps
module usage_monitor_readout_monitor
    import usage_monitor_pkg::*;
(
    input wire logic                     CORE_CLK,
    input wire logic                     RESET,
    input wire logic                     REQ_VALID,
    input wire logic                     REQ_WRITE,
    input wire logic                     REQ_SECURE,
    input wire usage_monitor_pkg::addr_t REQ_ADDR,
    input wire usage_monitor_pkg::word_t REQ_WDATA,
    input wire logic                     RSP_VALID,
    input wire usage_monitor_pkg::word_t RSP_RDATA,
    input wire logic                     MONITORING_SUPPORTED,
    input wire logic                     STORAGE_CAPTURE_SUPPORTED,
    input wire logic                     BW_MON_SUPPORTED,
    input wire logic                     BW_WRITE_VALID,
    input wire logic                     BW_WRITE_SECURE,
    input wire usage_monitor_pkg::word_t BW_WRITE_DATA
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RESET);
    // request shapes used by several properties
    sequence s_read(a);
        REQ_VALID && !REQ_WRITE && REQ_ADDR == a;
    endsequence
    sequence s_bw_write;
        REQ_VALID && REQ_WRITE && REQ_ADDR == BW_COUNTER_OFS;
    endsequence
    a_rsp_follows_req: assert property (REQ_VALID |=> RSP_VALID)
        else $error("no answer one cycle after a request");
    a_idle_rsp_quiet: assert property (!REQ_VALID |=> !RSP_VALID
        && RSP_RDATA == 32'h0000_0000) else $error("answer without request");
    a_write_reads_zero: assert property (REQ_VALID && REQ_WRITE |=>
        RSP_RDATA == 32'h0000_0000) else $error("write answered with data");
    a_absent_page_zero: assert property (REQ_VALID &&
        !MONITORING_SUPPORTED |=> RSP_RDATA == 32'h0000_0000)
        else $error("absent monitoring returned data");
    a_storage_absent_zero: assert property (s_read(STORAGE_SNAP_OFS) ##0
        !STORAGE_CAPTURE_SUPPORTED |=> RSP_RDATA == 32'h0000_0000)
        else $error("absent storage snapshot returned data");
    a_counter_absent_zero: assert property (s_read(BW_COUNTER_OFS) ##0
        !BW_MON_SUPPORTED |=> RSP_RDATA == 32'h0000_0000)
        else $error("absent counter returned data");
    a_selector_top_zero: assert property (s_read(SELECTOR_OFS) |=>
        RSP_RDATA[31:16] == 16'h0000) else $error("selector top bits set");
    a_counter_write_absent: assert property (s_bw_write ##0
        !BW_MON_SUPPORTED |=> !BW_WRITE_VALID)
        else $error("counter write passed while absent");
    a_counter_write_info: assert property (BW_WRITE_VALID |->
        $past(REQ_VALID && REQ_WRITE && REQ_ADDR == BW_COUNTER_OFS)
        && BW_WRITE_DATA == $past(REQ_WDATA)
        && BW_WRITE_SECURE == $past(REQ_SECURE))
        else $error("counter write notice does not match request");
    a_write_info_held: assert property (!BW_WRITE_VALID |->
        $stable(BW_WRITE_DATA) && $stable(BW_WRITE_SECURE))
        else $error("counter write notice changed without write");
endmodule // usage_monitor_readout_monitor

bind usage_monitor_readout usage_monitor_readout_monitor monitor_inst (
    .CORE_CLK, .RESET, .REQ_VALID, .REQ_WRITE, .REQ_SECURE, .REQ_ADDR,
    .REQ_WDATA, .RSP_VALID, .RSP_RDATA, .MONITORING_SUPPORTED,
    .STORAGE_CAPTURE_SUPPORTED, .BW_MON_SUPPORTED, .BW_WRITE_VALID,
    .BW_WRITE_SECURE, .BW_WRITE_DATA);

// File: testbench/usage_monitor_readout_tb.sv
// self-checking bench for the usage monitor readout registers
`timescale 1ns/1ps
module usage_monitor_readout_tb;
    import usage_monitor_pkg::*;
    localparam int NM = 4;
    localparam int SC = 4;
    logic                  CORE_CLK, RESET, REQ_VALID, REQ_WRITE, REQ_SECURE;
    logic                  RSP_VALID, BW_WRITE_VALID, BW_WRITE_SECURE;
    addr_t                 REQ_ADDR;
    word_t                 REQ_WDATA, RSP_RDATA, BW_WRITE_DATA, rd, w;
    index_t                BW_WRITE_INDEX;
    index_t [1:0]          sel;
    logic [4:0]            sup;
    logic [1:0]            cap;
    value_t [1:0][NM-1:0]  su;
    logic [1:0][NM-1:0]    snr, bnr, sce;
    logic [1:0][NM-1:0][43:0] bbc;
    word_t [1:0]           cs, cb;
    int                    fail_count, comparisons, seed, b, m, i;

    usage_monitor_readout #(.NUM_MON(NM), .BW_COUNT_W(44), .SCALE(SC))
    usage_monitor_readout_inst (.CORE_CLK, .RESET, .REQ_VALID, .REQ_WRITE,
        .REQ_SECURE, .REQ_ADDR, .REQ_WDATA, .RSP_VALID, .RSP_RDATA,
        .MONITORING_SUPPORTED(sup[0]), .STORAGE_MON_SUPPORTED(sup[1]),
        .STORAGE_CAPTURE_SUPPORTED(sup[2]), .BW_MON_SUPPORTED(sup[3]),
        .BW_CAPTURE_SUPPORTED(sup[4]), .STORAGE_USAGE(su),
        .STORAGE_NOT_READY(snr), .BW_BYTE_COUNT(bbc), .BW_NOT_READY(bnr),
        .BW_SCALING_ENABLE(sce), .CAPTURE_EVENT(cap), .BW_WRITE_VALID,
        .BW_WRITE_SECURE, .BW_WRITE_INDEX, .BW_WRITE_DATA);

    // expected live counter word, rounding before the shift
    function automatic word_t live(int k, int j);
        logic [44:0] r;
        r = {1'b0, bbc[k][j]};
        if (sce[k][j]) r = (r + 45'h8) >> SC;
        return {bnr[k][j], r[30:0]};
    endfunction

    task automatic chk_word(word_t e, word_t g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic chk_bit(logic e, logic g);
        chk_word({31'h0, e}, {31'h0, g});
    endtask
    // one access, answer sampled one cycle later
    task automatic acc(logic s, logic wr, addr_t a, word_t d);
        @(negedge CORE_CLK);
        {REQ_VALID, REQ_SECURE, REQ_WRITE, REQ_ADDR, REQ_WDATA} <=
            {1'b1, s, wr, a, d};
        @(negedge CORE_CLK);
        REQ_VALID <= 1'b0;
        chk_bit(1'b1, RSP_VALID);
        rd = RSP_RDATA;
    endtask
    task automatic rdchk(logic s, addr_t a, word_t e);
        acc(s, 1'b0, a, 32'h0000_0000);
        chk_word(e, rd);
    endtask
    // new random live monitor inputs
    task automatic shake();
        @(negedge CORE_CLK);
        for (int k = 0; k < 2; k++) begin
            for (int j = 0; j < NM; j++) begin
                su[k][j] = value_t'($random(seed));
                bbc[k][j] = 44'({$random(seed), $random(seed)});
            end
        end
        {snr, bnr, sce} = 24'($random(seed));
    endtask
    task automatic capture(int k);
        @(negedge CORE_CLK);
        cap[k] <= 1'b1;
        cs[k] = {snr[k][sel[k]], su[k][sel[k]]};
        cb[k] = live(k, sel[k]);
        @(negedge CORE_CLK);
        cap[k] <= 1'b0;
    endtask
    task automatic final_report();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // free-running core clock
    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        fail_count++;
        final_report();
    end
    // main sequence
    initial begin
        seed = 89;
        fail_count = 0;
        comparisons = 0;
        {REQ_VALID, REQ_WRITE, REQ_SECURE, cap, REQ_ADDR, REQ_WDATA} = '0;
        {sel, su, bbc, snr, bnr, sce} = '0;
        sup = 5'h1f;
        RESET = 1'b1;
        repeat (8) @(posedge CORE_CLK);
        @(negedge CORE_CLK) RESET = 1'b0;
        for (b = 0; b < 2; b++) begin
            rdchk(b[0], STORAGE_SNAP_OFS, SNAPSHOT_RST);
            rdchk(b[0], BW_SNAP_OFS, SNAPSHOT_RST);
        end
        $display("test reset values done");
        for (i = 0; i < 40; i++) begin
            b = $random(seed) & 1;
            m = $random(seed) & 3;
            acc(b[0], 1'b1, SELECTOR_OFS, 32'(m));
            sel[b] = index_t'(m);
            rdchk(b[0], SELECTOR_OFS, 32'(m));
            shake();
            rdchk(b[0], BW_COUNTER_OFS, live(b, m));
            capture(b);
            shake();
            rdchk(b[0], STORAGE_SNAP_OFS, cs[b]);
            rdchk(b[0], BW_SNAP_OFS, cb[b]);
            rdchk(!b[0], BW_COUNTER_OFS, live(1 - b, sel[1 - b]));
        end
        $display("test random reads and captures done");
        w = $random(seed);
        acc(1'b1, 1'b1, STORAGE_SNAP_OFS, w);
        rdchk(1'b1, STORAGE_SNAP_OFS, w);
        acc(1'b0, 1'b1, BW_SNAP_OFS, w);
        rdchk(1'b0, BW_SNAP_OFS, w);
        acc(1'b0, 1'b1, BW_COUNTER_OFS, w);
        chk_bit(1'b1, BW_WRITE_VALID);
        chk_word(w, BW_WRITE_DATA);
        chk_word({16'h0, sel[0]},
                 {15'h0, BW_WRITE_SECURE, BW_WRITE_INDEX});
        $display("test software writes done");
        rdchk(1'b0, 12'h804, 32'h0000_0000);
        acc(1'b0, 1'b1, SELECTOR_OFS, 32'h0000_0004);
        rdchk(1'b0, BW_COUNTER_OFS, 32'h0000_0000);
        acc(1'b0, 1'b1, SELECTOR_OFS, 32'h0000_0000);
        sup = 5'h17;
        rdchk(1'b0, BW_COUNTER_OFS, 32'h0000_0000);
        acc(1'b0, 1'b1, BW_COUNTER_OFS, ~w);
        chk_bit(1'b0, BW_WRITE_VALID);
        chk_word(w, BW_WRITE_DATA);
        sup = 5'h0f;
        rdchk(1'b1, BW_SNAP_OFS, 32'h0000_0000);
        sup = 5'h1b;
        rdchk(1'b0, STORAGE_SNAP_OFS, 32'h0000_0000);
        acc(1'b1, 1'b1, STORAGE_SNAP_OFS, ~w);
        sup = 5'h1d;
        rdchk(1'b1, STORAGE_SNAP_OFS, 32'h0000_0000);
        sup = 5'h1f;
        rdchk(1'b1, STORAGE_SNAP_OFS, w);
        sup = 5'h1e;
        rdchk(1'b0, SELECTOR_OFS, 32'h0000_0000);
        $display("test absent registers done");
        sup = 5'h1f;
        @(negedge CORE_CLK) RESET = 1'b1;
        repeat (2) @(negedge CORE_CLK);
        RESET = 1'b0;
        chk_bit(1'b0, BW_WRITE_VALID);
        chk_word(32'h0000_0000, BW_WRITE_DATA);
        rdchk(1'b1, SELECTOR_OFS, 32'h0000_0000);
        rdchk(1'b1, STORAGE_SNAP_OFS, SNAPSHOT_RST);
        rdchk(1'b0, BW_SNAP_OFS, SNAPSHOT_RST);
        $display("test mid-run reset done");
        final_report();
    end
endmodule // usage_monitor_readout_tb
